// ===== hdl/udc_ctrl.sv
// Notes on behaviour
// - Accept half-word and word register accesses.
// - Mask bits 15..7 gate matching status flags.
// - LPM wake bit self-clears after signalling ends.
// - Suspend flag after 3 ms bus silence.
// - Force suspend drives suspend while set; zero releases it.
// - Low-power bit cleared by wakeup or software.
// - Power down disconnects transceiver and analog.
// - Force reset acts as bus reset, raises event.
// - Hardware sets event flags; masked flags interrupt.
// - One request held while any enabled flag set.
// - Flags clear on written zero only.
// - Transfer flag read-only, follows endpoint pending.
// - Endpoint interrupt independent of transfer mask.
// - Direction and endpoint index readable in status.
// - Memory overrun flags, withholds ack on receive, forces stuff on transmit.
// - Isochronous overrun is not retried, data lost.
// - Wake activity under force suspend sets flag, clears low-power, wake line.
`include "udc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module udc_ctrl #(
    parameter int IDLE_CYCLES = `UDC_IDLE_MS * `UDC_CLK_MHZ * 1000,
    parameter int WAKE_CYCLES = `UDC_LPM_WAKE_US * `UDC_CLK_MHZ
) (
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        reset_i,
    // Register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [1:0]  reg_size_i,
    input  wire logic [31:0] reg_wdata_i,
    output logic      [31:0] reg_rdata_o,
    // Protocol engine events, one-cycle pulses
    input  wire logic        ev_pktmem_ovr_i,
    input  wire logic        ev_error_i,
    input  wire logic        ev_bus_reset_i,
    input  wire logic        ev_sof_i,
    input  wire logic        ev_lpm_sleep_i,
    input  wire logic        ev_traffic_i,
    // Endpoint transfer-complete summary
    input  wire logic        ep_pending_i,
    input  wire logic        ep_dir_i,
    input  wire logic [3:0]  ep_index_i,
    input  wire logic        ep_isochronous_i,
    // Bus wakeup activity from the analog front end
    input  wire logic        bus_activity_i,
    // Control outputs
    output logic             irq_o,
    output logic             ep_irq_o,
    output logic             suspend_o,
    output logic             low_power_o,
    output logic             analog_off_o,
    output logic             core_reset_o,
    output logic             resume_sig_o,
    output logic             lpm_resume_sig_o,
    output logic             wakeup_o,
    output logic             withhold_ack_o,
    output logic             force_stuff_err_o,
    output logic             retry_expected_o
);

    // ======================================================================
    // Helpers
    function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] o,
                                    input logic w);
        return w && (a == o);
    endfunction : wr_hit

    logic [15:0] ctrl_ff;
    logic [15:0] flags_ff;
    logic [1:0]  act_s1_ff;
    logic [1:0]  act_s2_ff;
    logic        act_prev_ff;
    logic [31:0] idle_cnt_ff;
    logic [31:0] missed_frame_flag_cnt_ff;
    logic [31:0] wake_cnt_ff;
    udc_pkg::udc_wake_t wake_st_ff;
    logic        wr_ctrl;
    logic        wr_stat;
    logic        wake_ev;
    logic        wake_end;
    logic        idle_suspend_flag_ev;
    logic        missed_frame_flag_ev;
    logic [15:0] set_v;
    logic [15:0] status_v;

    // Both sizes carry control in the low half-word.
    assign wr_ctrl = wr_hit(reg_addr_i, `UDC_OFS_CONTROL, reg_wr_i)
                     && (reg_size_i != 2'h0);
    assign wr_stat = wr_hit(reg_addr_i, `UDC_OFS_STATUS, reg_wr_i)
                     && (reg_size_i != 2'h0);

    // ======================================================================
    // Wake activity synchroniser; the pin is asynchronous to the clock.
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            act_s1_ff   <= 2'h0;
            act_s2_ff   <= 2'h0;
            act_prev_ff <= 1'b0;
        end else begin
            act_s1_ff   <= {1'b0, bus_activity_i};
            act_s2_ff   <= act_s1_ff;
            act_prev_ff <= act_s2_ff[0];
        end
    end

    assign wake_ev = act_s2_ff[0] && !act_prev_ff && ctrl_ff[`UDC_B_FORCE_SUSPEND];

    // ======================================================================
    // Idle timers. Checking is off during suspend to avoid repeat events.
    // The suspend count saturates, so one silent stretch raises the
    // suspend flag once; the frame-miss count wraps and keeps firing.
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            idle_cnt_ff <= 32'h0;
            missed_frame_flag_cnt_ff <= 32'h0;
        end else if (ev_traffic_i || ev_sof_i || ctrl_ff[`UDC_B_FORCE_SUSPEND]) begin
            idle_cnt_ff <= 32'h0;
            missed_frame_flag_cnt_ff <= 32'h0;
        end else begin
            idle_cnt_ff <= (idle_cnt_ff == 32'(IDLE_CYCLES)) ? idle_cnt_ff
                           : idle_cnt_ff + 32'h1;
            missed_frame_flag_cnt_ff <= (missed_frame_flag_cnt_ff == 32'(IDLE_CYCLES / 3)) ? 32'h0
                           : missed_frame_flag_cnt_ff + 32'h1;
        end
    end

    assign idle_suspend_flag_ev = (idle_cnt_ff == 32'(IDLE_CYCLES - 1));
    assign missed_frame_flag_ev = (missed_frame_flag_cnt_ff == 32'(IDLE_CYCLES / 3));

    // ======================================================================
    // LPM resume signalling timer.
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            wake_st_ff  <= udc_pkg::UDC_IDLE;
            wake_cnt_ff <= 32'h0;
        end else begin
            unique case (wake_st_ff)
                udc_pkg::UDC_IDLE: begin
                    wake_cnt_ff <= 32'h0;
                    if (ctrl_ff[`UDC_B_LPM_WAKE])
                        wake_st_ff <= udc_pkg::UDC_SIGNL;
                end
                udc_pkg::UDC_SIGNL: begin
                    wake_cnt_ff <= wake_cnt_ff + 32'h1;
                    if (wake_cnt_ff == 32'(WAKE_CYCLES - 1))
                        wake_st_ff <= udc_pkg::UDC_DONE;
                end
                udc_pkg::UDC_DONE: wake_st_ff <= udc_pkg::UDC_IDLE;
                default: wake_st_ff <= udc_pkg::UDC_IDLE;
            endcase
        end
    end

    assign wake_end = (wake_st_ff == udc_pkg::UDC_DONE);

    // ======================================================================
    // Control register.
    // A byte write is dropped whole, since half a register update could
    // leave mask and mode bits in a mix the software never asked for.
    // Hardware clears come last so they win over a same-cycle write.
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl_ff <= `UDC_CTRL_RESET;
        end else begin
            if (wr_ctrl)
                ctrl_ff <= reg_wdata_i[15:0] & `UDC_CTRL_WMASK;
            if (wake_end)
                ctrl_ff[`UDC_B_LPM_WAKE] <= 1'b0;
            if (wake_ev)
                ctrl_ff[`UDC_B_LOWPWR] <= 1'b0;
        end
    end

    // ======================================================================
    // Event flags: hardware set beats a software clear in the same cycle.
    always_comb begin
        set_v = 16'h0;
        set_v[`UDC_B_PKTOVR] = ev_pktmem_ovr_i;
        set_v[`UDC_B_ERR]    = ev_error_i;
        set_v[`UDC_B_WAKE]   = wake_ev;
        set_v[`UDC_B_IDLE_SUSPEND_FLAG]   = idle_suspend_flag_ev;
        set_v[`UDC_B_BUSRST] = ev_bus_reset_i || ctrl_ff[`UDC_B_FORCE_BUS_RESET];
        set_v[`UDC_B_SOF]    = ev_sof_i;
        set_v[`UDC_B_MISSED_FRAME_FLAG]   = missed_frame_flag_ev;
        set_v[`UDC_B_LPM]    = ev_lpm_sleep_i;
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            flags_ff <= `UDC_STAT_RESET;
        end else if (wr_stat) begin
            flags_ff <= ((flags_ff & reg_wdata_i[15:0]) | set_v)
                        & `UDC_STAT_W0MASK;
        end else begin
            flags_ff <= (flags_ff | set_v) & `UDC_STAT_W0MASK;
        end
    end

    always_comb begin
        status_v = flags_ff;
        status_v[`UDC_B_XFER] = ep_pending_i;
        status_v[`UDC_B_DIR]  = ep_dir_i;
        status_v[3:0]         = ep_index_i;
    end

    // ======================================================================
    // Outputs, all registered.
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            reg_rdata_o       <= 32'h0;
            irq_o             <= 1'b0;
            ep_irq_o          <= 1'b0;
            suspend_o         <= 1'b0;
            low_power_o       <= 1'b0;
            analog_off_o      <= 1'b1;
            core_reset_o      <= 1'b1;
            resume_sig_o      <= 1'b0;
            lpm_resume_sig_o  <= 1'b0;
            wakeup_o          <= 1'b0;
            withhold_ack_o    <= 1'b0;
            force_stuff_err_o <= 1'b0;
            retry_expected_o  <= 1'b1;
        end else begin
            if (reg_rd_i && reg_addr_i == `UDC_OFS_CONTROL)
                reg_rdata_o <= {16'h0, ctrl_ff};
            else if (reg_rd_i && reg_addr_i == `UDC_OFS_STATUS)
                reg_rdata_o <= {16'h0, status_v};
            else
                reg_rdata_o <= 32'h0;
            irq_o <= |(status_v[`UDC_MASK_HI:`UDC_MASK_LO]
                       & ctrl_ff[`UDC_MASK_HI:`UDC_MASK_LO]);
            ep_irq_o          <= ep_pending_i;
            suspend_o         <= ctrl_ff[`UDC_B_FORCE_SUSPEND];
            low_power_o       <= ctrl_ff[`UDC_B_LOWPWR];
            analog_off_o      <= ctrl_ff[`UDC_B_ANALOG_POWER_DOWN];
            core_reset_o      <= ctrl_ff[`UDC_B_FORCE_BUS_RESET] || ctrl_ff[`UDC_B_ANALOG_POWER_DOWN];
            resume_sig_o      <= ctrl_ff[`UDC_B_RESUME];
            lpm_resume_sig_o  <= (wake_st_ff == udc_pkg::UDC_SIGNL);
            wakeup_o          <= wake_ev;
            withhold_ack_o    <= ev_pktmem_ovr_i && ep_dir_i;
            force_stuff_err_o <= ev_pktmem_ovr_i && !ep_dir_i;
            retry_expected_o  <= !ep_isochronous_i;
        end
    end

endmodule : udc_ctrl

`default_nettype wire

// ===== inc/udc_map.svh
`ifndef UDC_MAP_SVH
`define UDC_MAP_SVH

// ==========================================================================
// Register offsets and layouts
`define UDC_OFS_CONTROL     8'h40
`define UDC_OFS_STATUS      8'h44
`define UDC_CTRL_RESET      16'h0003
`define UDC_STAT_RESET      16'h0000
`define UDC_CTRL_WMASK      16'hFFBF
`define UDC_STAT_W0MASK     16'h7F80
`define UDC_MASK_HI         15
`define UDC_MASK_LO         7
`define UDC_B_LPM_WAKE      5
`define UDC_B_RESUME        4
`define UDC_B_FORCE_SUSPEND         3
`define UDC_B_LOWPWR        2
`define UDC_B_ANALOG_POWER_DOWN          1
`define UDC_B_FORCE_BUS_RESET          0
`define UDC_B_XFER          15
`define UDC_B_PKTOVR        14
`define UDC_B_ERR           13
`define UDC_B_WAKE          12
`define UDC_B_IDLE_SUSPEND_FLAG          11
`define UDC_B_BUSRST        10
`define UDC_B_SOF           9
`define UDC_B_MISSED_FRAME_FLAG          8
`define UDC_B_LPM           7
`define UDC_B_DIR           4

// ==========================================================================
// Timing
`define UDC_CLK_MHZ         125
`define UDC_IDLE_MS         3
`define UDC_LPM_WAKE_US     50

`endif

// ===== inc/udc_pkg.sv
package udc_pkg;
    typedef enum logic [1:0] {
        UDC_IDLE  = 2'b00,
        UDC_SIGNL = 2'b01,
        UDC_DONE  = 2'b11
    } udc_wake_t;
endpackage : udc_pkg

// ===== verification/udc_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Port checks on the control block.
module udc_ctrl_checker (
    // Clock, reset and bus
    input wire logic        clk_sys_i,
    input wire logic        reset_i,
    input wire logic [31:0] reg_rdata_o,
    // Engine and endpoint inputs
    input wire logic        ev_pktmem_ovr_i,
    input wire logic        ep_pending_i,
    input wire logic        ep_dir_i,
    input wire logic        ep_isochronous_i,
    // Watched outputs
    input wire logic        ep_irq_o,
    input wire logic        low_power_o,
    input wire logic        analog_off_o,
    input wire logic        core_reset_o,
    input wire logic        wakeup_o,
    input wire logic        withhold_ack_o,
    input wire logic        force_stuff_err_o,
    input wire logic        retry_expected_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    a_upper_zero: assert property (reg_rdata_o[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    a_ep_irq_follow: assert property (ep_pending_i |=> ep_irq_o)
        else $error("endpoint request missing");
    a_ovr_rx_ack: assert property (ev_pktmem_ovr_i && ep_dir_i
        |=> withhold_ack_o && !force_stuff_err_o)
        else $error("receive overrun not handled");
    a_ovr_tx_stuff: assert property (ev_pktmem_ovr_i && !ep_dir_i
        |=> force_stuff_err_o && !withhold_ack_o)
        else $error("transmit overrun not handled");
    a_ovr_cause: assert property ((withhold_ack_o || force_stuff_err_o)
        |-> $past(ev_pktmem_ovr_i))
        else $error("overrun reaction without cause");
    a_iso_no_retry: assert property (ep_isochronous_i |=> !retry_expected_o)
        else $error("retry expected on isochronous");
    a_wake_single: assert property (wakeup_o |=> !wakeup_o)
        else $error("wake line longer than one cycle");
    a_wake_lowpwr: assert property (wakeup_o |-> ##[0:2] !low_power_o)
        else $error("low power kept after wake");
    a_analog_power_down_reset: assert property (analog_off_o |-> core_reset_o)
        else $error("core runs while powered down");
endmodule : udc_ctrl_checker
bind udc_ctrl udc_ctrl_checker u_chk (.*);
`default_nettype wire

// ===== verification/udc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Host side: packets at a steady rate keep the idle timer quiet.
module udc_host_model (
    input  wire logic clk_sys_i,
    input  wire logic alive_i,
    input  wire logic wake_i,
    output logic      ev_traffic_o,
    output logic      bus_activity_o
);
    logic [2:0] gap_ff = 3'h0;
    logic       pkt_ff = 1'b0;
    // A silent host is how suspend is requested, so alive_i gates traffic.
    always @(posedge clk_sys_i) begin
        gap_ff <= gap_ff + 3'h1;
        pkt_ff <= alive_i && (gap_ff == 3'h7);
    end
    assign ev_traffic_o   = pkt_ff;
    assign bus_activity_o = wake_i;
endmodule : udc_host_model
`default_nettype wire

// ===== verification/udc_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Bench with a register and flag model.
module udc_ctrl_tb_top;
    localparam int IDLE = 30;
    logic clk_sys_i = 1'b0, reset_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [1:0] reg_size_i = 2'h1;
    logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, rdat;
    logic [4:0] ev = 5'h00;
    logic ep_pending_i = 1'b0, ep_dir_i = 1'b0, ep_isochronous_i = 1'b0;
    logic [3:0] ep_index_i = 4'h0;
    logic alive = 1'b1, wake = 1'b0, ev_traffic_i, bus_activity_i;
    logic irq_o, ep_irq_o, suspend_o, low_power_o, analog_off_o;
    logic core_reset_o, resume_sig_o, lpm_resume_sig_o, wakeup_o;
    logic withhold_ack_o, force_stuff_err_o, retry_expected_o;
    wire logic ev_pktmem_ovr_i = ev[4], ev_error_i = ev[3];
    wire logic ev_bus_reset_i = ev[2], ev_sof_i = ev[1];
    wire logic ev_lpm_sleep_i = ev[0];
    int failures = 0, n_checks = 0, ctrl = 0, stat = 0, b;
    int pos[$] = '{7, 9, 10, 13, 14};
    always #4 clk_sys_i = ~clk_sys_i;
    udc_ctrl #(.IDLE_CYCLES(IDLE), .WAKE_CYCLES(5)) DUT (.*);
    udc_host_model HOST (.clk_sys_i, .alive_i(alive), .wake_i(wake),
        .ev_traffic_o(ev_traffic_i), .bus_activity_o(bus_activity_i));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : cyc
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [1:0] s, input logic [31:0] d);
        {reg_wr_i, reg_rd_i, reg_addr_i, reg_size_i} = {w, !w, a, s};
        reg_wdata_i = d;
        cyc(1);
        rdat = reg_rdata_o;
        {reg_wr_i, reg_rd_i} = 2'b00;
        cyc(1);
    endtask : acc
    task automatic rd(input logic [7:0] a);
        acc(1'b0, a, 2'h2, 32'h0);
    endtask : rd
    task automatic wctl(input int d);
        acc(1'b1, 8'h40, 2'h1, d);
        ctrl = d;
    endtask : wctl
    task automatic fire(input int i);
        ev[i] = 1'b1;
        cyc(1);
        ev[i] = 1'b0;
        stat = stat | (1 << pos[i]);
        cyc(1);
    endtask : fire
    task automatic complete_run();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run
    // A hang costs one failure and ends the run the normal way.
    initial begin
        #80000;
        failures++;
        complete_run();
    end
    initial begin
        void'($urandom(19));
        cyc(4);
        check(32'({analog_off_o, core_reset_o}), 32'h3);
        reset_i = 1'b0;
        cyc(1);
        rd(8'h40);
        check(rdat, 32'h3);
        rd(8'h48);
        check(rdat, 32'h0);
        wctl(32'hFFC0);
        acc(1'b1, 8'h40, 2'h0, 32'h0);
        rd(8'h40);
        check(rdat, 32'hFF80);
        // Reset leaves the forced bus reset on, which raised its flag.
        acc(1'b1, 8'h44, 2'h2, 32'h0);
        for (int k = 0; k < 16; k++) begin
            b = $urandom_range(4, 0);
            wctl($urandom & 32'hFF80);
            fire(b);
            check(32'(irq_o), 32'((stat & ctrl) != 0));
            rd(8'h44);
            check(rdat, stat);
            acc(1'b1, 8'h44, 2'h2, k[0] ? 32'hFFFF : ~(1 << pos[b]));
            if (!k[0]) stat = stat & ~(1 << pos[b]);
        end
        wctl(0);
        {ep_pending_i, ep_dir_i, ep_index_i} = {2'b11, 4'($urandom)};
        cyc(2);
        check(32'({ep_irq_o, irq_o}), 32'h2);
        acc(1'b1, 8'h44, 2'h1, 32'h7FFF);
        rd(8'h44);
        check(rdat, stat | 32'h8010 | ep_index_i);
        {ep_pending_i, ep_dir_i, ep_index_i, ep_isochronous_i} = 7'h01;
        fire(4);
        check(32'(retry_expected_o), 32'h0);
        ep_dir_i = 1'b1;
        fire(4);
        {ep_dir_i, ep_isochronous_i} = 2'b00;
        acc(1'b1, 8'h44, 2'h1, 32'h0);
        alive = 1'b0;
        cyc(IDLE + 4);
        rd(8'h44);
        check(rdat & 32'h0900, 32'h0900);
        wctl(32'hC);
        check(32'({suspend_o, low_power_o}), 32'h3);
        wake = 1'b1;
        cyc(6);
        check(32'(low_power_o), 32'h0);
        rd(8'h40);
        check(rdat, 32'h8);
        rd(8'h44);
        check(rdat & 32'h1000, 32'h1000);
        {wake, alive} = 2'b01;
        wctl(32'h20);
        cyc(1);
        check(32'(lpm_resume_sig_o), 32'h1);
        cyc(12);
        rd(8'h40);
        check(rdat, 32'h0);
        wctl(32'h10);
        check(32'(resume_sig_o), 32'h1);
        wctl(32'h0);
        check(32'(resume_sig_o), 32'h0);
        wctl(32'h1);
        rd(8'h44);
        check(rdat & 32'h0400, 32'h0400);
        wctl(32'h2);
        check(32'({analog_off_o, core_reset_o}), 32'h3);
        complete_run();
    end
endmodule : udc_ctrl_tb_top
`default_nettype wire
